/* File: pc_stack_params.svh */
`ifndef PC_STACK_PARAMS_SVH
`define PC_STACK_PARAMS_SVH

// register byte offsets
`define OFS_COUNTER_LOW   8'h00
`define OFS_HIGH_LATCH    8'h04
`define OFS_UPPER_LATCH   8'h08
`define OFS_STACK_STATUS  8'h0C
`define OFS_TOP_LOW       8'h10
`define OFS_TOP_HIGH      8'h14
`define OFS_TOP_UPPER     8'h18
`define OFS_STACK_CONFIG  8'h1C

// status and config register bit positions
`define BIT_FULL          7
`define BIT_UNDERFLOW     6
`define BIT_ORE           0

// counter values and overflow reset default
`define PC_RESET_VECTOR   21'h000000
`define PC_VECTOR_HIGH    21'h000008
`define PC_VECTOR_LOW     21'h000018
`define PC_STEP           21'h000002
`define ORE_RESET         1'b1

// stack geometry
`define STACK_DEPTH       31
`define STACK_LAST        5'h1F
`define STACK_NEAR_FULL   5'h1E

// bus answers
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

/* File: pc_stack_pkg.sv */
package pc_stack_pkg;

    // one sequencer operation per cycle; after op_none, highest priority first
    typedef enum logic [3:0] {
        op_none,
        op_reset,
        op_int,
        op_call,
        op_jump,
        op_return,
        op_push,
        op_pop,
        op_low_write,
        op_advance
    } op_t;

endpackage

/* File: stack_ram.sv */
`timescale 1ns/100ps
`default_nettype none

module stack_ram #(
    parameter int DEPTH = 31,
    parameter int WIDTH = 21
) (
    input  wire logic             clk,
    input  wire logic             we,
    input  wire logic [4:0]       waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [4:0]       raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [1:DEPTH];

    // ******************************************************
    // entries 1..DEPTH, level zero has no storage
    // ******************************************************
    genvar i;
    generate
        for (i = 1; i <= DEPTH; i++) begin : g_entry
            always_ff @(posedge clk) begin
                if (we && waddr == 5'(i)) begin
                    mem[i] <= wdata;
                end
            end
        end
    endgenerate

    // level zero and out-of-range levels read as zero
    wire rd_valid = (raddr != 5'h00) && ({27'h0, raddr} <= 32'(DEPTH));
    assign rdata = rd_valid ? mem[raddr] : '0;

endmodule

`default_nettype wire

/* File: pc_return_stack.sv */
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pc_stack_params.svh"

module pc_return_stack #(
    parameter int        PC_W       = 21,
    parameter int        DEPTH      = `STACK_DEPTH,
    parameter int        ADDR_W     = 8,
    parameter logic [21:0] PROG_BYTES = 22'h010000
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              core_rst_n,
    // sequencer requests, one-cycle pulses
    input  wire logic              seq_advance,
    input  wire logic              seq_call,
    input  wire logic              seq_jump,
    input  wire logic [PC_W-1:0]   seq_target,
    input  wire logic              seq_return,
    input  wire logic              seq_int_ack,
    input  wire logic              seq_int_high,
    input  wire logic              seq_push,
    input  wire logic              seq_pop,
    input  wire logic              seq_low_write,
    input  wire logic [7:0]        seq_low_wdata,
    input  wire logic              seq_low_read,
    input  wire logic [15:0]       mem_data,
    output logic      [PC_W-1:0]   pc,
    output logic      [15:0]       fetch_word,
    output logic                   stack_reset,
    output logic      [7:0]        stack_status,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ******************************************************
    // state
    // ******************************************************
    logic [7:0]        high_byte_latch;
    logic [4:0]        upper_byte_latch;
    logic [4:0]        stack_level;
    logic              stack_full_flag;
    logic              stack_underflow_flag;
    logic              overflow_reset_enable;
    logic [PC_W-1:0]   top_entry;

    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0]        w_byte;
    logic              w_lane0;

    logic [PC_W-1:0]   next_pc;
    logic [4:0]        next_level;
    logic              ram_we;
    logic [4:0]        ram_waddr;
    logic [PC_W-1:0]   ram_wdata;
    logic              set_full;
    logic              set_unf;
    logic              stk_rst;

    // ******************************************************
    // operation select
    // ******************************************************
    // the sequencer raises at most one of these; a fixed order settles any overlap
    pc_stack_pkg::op_t op;
    assign op = !core_rst_n    ? pc_stack_pkg::op_reset :
                seq_int_ack    ? pc_stack_pkg::op_int :
                seq_call       ? pc_stack_pkg::op_call :
                seq_jump       ? pc_stack_pkg::op_jump :
                seq_return     ? pc_stack_pkg::op_return :
                seq_push       ? pc_stack_pkg::op_push :
                seq_pop        ? pc_stack_pkg::op_pop :
                seq_low_write  ? pc_stack_pkg::op_low_write :
                seq_advance    ? pc_stack_pkg::op_advance :
                                 pc_stack_pkg::op_none;

    wire core_busy = (op != pc_stack_pkg::op_none);
    wire is_push   = (op == pc_stack_pkg::op_int) || (op == pc_stack_pkg::op_call) ||
                     (op == pc_stack_pkg::op_push);

    // ******************************************************
    // register bus decode
    // ******************************************************
    // bus writes wait for an idle sequencer cycle so no counter update is lost
    wire sw_wr       = aw_held && w_held && !s_axi_bvalid && !core_busy;
    wire wr_low      = (aw_addr == `OFS_COUNTER_LOW);
    wire wr_lath     = (aw_addr == `OFS_HIGH_LATCH);
    wire wr_latu     = (aw_addr == `OFS_UPPER_LATCH);
    wire wr_status   = (aw_addr == `OFS_STACK_STATUS);
    wire wr_top_lo   = (aw_addr == `OFS_TOP_LOW);
    wire wr_top_hi   = (aw_addr == `OFS_TOP_HIGH);
    wire wr_top_up   = (aw_addr == `OFS_TOP_UPPER);
    wire wr_cfg      = (aw_addr == `OFS_STACK_CONFIG);
    wire wr_mapped   = wr_low || wr_lath || wr_latu || wr_status ||
                       wr_top_lo || wr_top_hi || wr_top_up || wr_cfg;
    wire wr_go       = sw_wr && w_lane0;

    wire rd_take     = s_axi_arvalid && s_axi_arready;
    wire rd_low      = (s_axi_araddr == `OFS_COUNTER_LOW);
    wire rd_lath     = (s_axi_araddr == `OFS_HIGH_LATCH);
    wire rd_latu     = (s_axi_araddr == `OFS_UPPER_LATCH);
    wire rd_status   = (s_axi_araddr == `OFS_STACK_STATUS);
    wire rd_top_lo   = (s_axi_araddr == `OFS_TOP_LOW);
    wire rd_top_hi   = (s_axi_araddr == `OFS_TOP_HIGH);
    wire rd_top_up   = (s_axi_araddr == `OFS_TOP_UPPER);
    wire rd_cfg      = (s_axi_araddr == `OFS_STACK_CONFIG);

    wire [7:0] status_word = {stack_full_flag, stack_underflow_flag, 1'b0, stack_level};

    wire [7:0] rd_byte = rd_low    ? pc[7:0] :
                         rd_lath   ? high_byte_latch :
                         rd_latu   ? {3'h0, upper_byte_latch} :
                         rd_status ? status_word :
                         rd_top_lo ? top_entry[7:0] :
                         rd_top_hi ? top_entry[15:8] :
                         rd_top_up ? {3'h0, top_entry[20:16]} :
                         rd_cfg    ? {7'h00, overflow_reset_enable} :
                                     8'h00;
    wire rd_mapped = rd_low || rd_lath || rd_latu || rd_status ||
                     rd_top_lo || rd_top_hi || rd_top_up || rd_cfg;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // top bytes written in place into the selected entry
    wire [PC_W-1:0] top_merged = wr_top_lo ? {top_entry[20:8], w_byte} :
                                 wr_top_hi ? {top_entry[20:16], w_byte, top_entry[7:0]} :
                                             {w_byte[4:0], top_entry[15:0]};
    wire wr_top = wr_top_lo || wr_top_hi || wr_top_up;

    // low byte write joins both latches, bit 0 forced low
    wire [7:0]      low_src   = (op == pc_stack_pkg::op_low_write) ? seq_low_wdata : w_byte;
    wire [PC_W-1:0] low_load  = {upper_byte_latch, high_byte_latch, low_src[7:1], 1'b0};

    // ******************************************************
    // return stack storage
    // ******************************************************
    // 31 x 21 private entries
    stack_ram #(
        .DEPTH (DEPTH),
        .WIDTH (PC_W)
    ) u_stack_ram (
        .clk   (clk),
        .we    (ram_we),
        .waddr (ram_waddr),
        .wdata (ram_wdata),
        .raddr (stack_level),
        .rdata (top_entry)
    );

    // ******************************************************
    // counter and stack next state
    // ******************************************************
    always_comb begin
        next_pc    = pc;
        next_level = stack_level;
        ram_we     = 1'b0;
        ram_waddr  = stack_level + 5'h01;
        ram_wdata  = pc;
        set_full   = 1'b0;
        set_unf    = 1'b0;
        stk_rst    = 1'b0;
        case (op)
            pc_stack_pkg::op_reset: begin
                next_pc    = `PC_RESET_VECTOR;
                next_level = 5'h00;
            end
            pc_stack_pkg::op_int: begin
                next_pc = seq_int_high ? `PC_VECTOR_HIGH : `PC_VECTOR_LOW;
            end
            pc_stack_pkg::op_call,
            pc_stack_pkg::op_jump: begin
                next_pc = {seq_target[PC_W-1:1], 1'b0};
            end
            pc_stack_pkg::op_return: begin
                if (stack_level == 5'h00) begin
                    next_pc = `PC_RESET_VECTOR;
                    set_unf = 1'b1;
                end else begin
                    next_pc    = {top_entry[PC_W-1:1], 1'b0};
                    next_level = stack_level - 5'h01;
                end
            end
            pc_stack_pkg::op_pop: begin
                if (stack_level == 5'h00) begin
                    set_unf = 1'b1;
                end else begin
                    next_level = stack_level - 5'h01;
                end
            end
            pc_stack_pkg::op_low_write: begin
                next_pc = low_load;
            end
            pc_stack_pkg::op_advance: begin
                next_pc = pc + `PC_STEP;
            end
            default: begin
                if (wr_go && wr_low) begin
                    next_pc = low_load;
                end
                if (wr_go && wr_status) begin
                    next_level = w_byte[4:0];
                end
                if (wr_go && wr_top && stack_level != 5'h00) begin
                    ram_we    = 1'b1;
                    ram_waddr = stack_level;
                    ram_wdata = top_merged;
                end
            end
        endcase

        // push increments then stores the current counter value, not advanced by the step
        if (is_push) begin
            if (stack_level < `STACK_NEAR_FULL) begin
                ram_we     = 1'b1;
                next_level = stack_level + 5'h01;
            end else if (stack_level == `STACK_NEAR_FULL) begin
                ram_we     = 1'b1;
                set_full   = 1'b1;
                next_level = `STACK_LAST;
                stk_rst    = overflow_reset_enable;
            end else begin
                set_full = 1'b1;
            end
        end

        if (set_unf && overflow_reset_enable) begin
            stk_rst = 1'b1;
        end

        // stack reset leaves pointer zero and restarts at the reset vector
        if (stk_rst) begin
            next_pc    = `PC_RESET_VECTOR;
            next_level = 5'h00;
        end
    end

    // ******************************************************
    // counter, pointer, flags
    // ******************************************************
    // counter register, bit 0 never set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc          <= `PC_RESET_VECTOR;
            stack_level <= 5'h00;
            stack_reset <= 1'b0;
        end else begin
            pc          <= {next_pc[PC_W-1:1], 1'b0};
            stack_level <= next_level;
            stack_reset <= stk_rst;
        end
    end

    // sticky flags, only power-on clears them besides software; set beats clear
    wire clr_full = wr_go && wr_status && !w_byte[`BIT_FULL];
    wire clr_unf  = wr_go && wr_status && !w_byte[`BIT_UNDERFLOW];
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stack_full_flag      <= 1'b0;
            stack_underflow_flag <= 1'b0;
        end else begin
            stack_full_flag      <= set_full || (stack_full_flag && !clr_full);
            stack_underflow_flag <= set_unf || (stack_underflow_flag && !clr_unf);
        end
    end

    assign stack_status = status_word;

    // ******************************************************
    // latches and configuration
    // ******************************************************
    // any low-byte read refreshes the latches; a latch write in the same cycle wins
    wire low_seen = seq_low_read || (rd_take && rd_low);
    always_ff @(posedge clk) begin
        if (!rst_n || !core_rst_n) begin
            high_byte_latch  <= 8'h00;
            upper_byte_latch <= 5'h00;
        end else begin
            if (wr_go && wr_lath) begin
                high_byte_latch <= w_byte;
            end else if (low_seen) begin
                high_byte_latch <= pc[15:8];
            end
            if (wr_go && wr_latu) begin
                upper_byte_latch <= w_byte[4:0];
            end else if (low_seen) begin
                upper_byte_latch <= pc[20:16];
            end
        end
    end

    // overflow reset option, on by default
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overflow_reset_enable <= `ORE_RESET;
        end else if (wr_go && wr_cfg) begin
            overflow_reset_enable <= w_byte[`BIT_ORE];
        end
    end

    // ******************************************************
    // fetch path
    // ******************************************************
    // beyond implemented memory the word reads as zero
    wire in_range = ({1'b0, pc} < PROG_BYTES);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fetch_word <= 16'h0000;
        end else begin
            fetch_word <= in_range ? mem_data : 16'h0000;
        end
    end

    // ******************************************************
    // axi4-lite write channel
    // ******************************************************
    // address and data are captured separately and joined when both are held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (sw_wr) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w_held  <= 1'b0;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (sw_wr) begin
            w_held <= 1'b0;
        end
    end

    // unmapped offsets answer slverr and change nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (sw_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ******************************************************
    // axi4-lite read channel
    // ******************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: pc_return_stack_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// port checker
// ****
module pc_return_stack_chk #(
    parameter logic [21:0] PROG_BYTES = 22'h010000
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        core_rst_n,
    input wire logic        seq_advance,
    input wire logic        seq_call,
    input wire logic        seq_jump,
    input wire logic [20:0] seq_target,
    input wire logic        seq_return,
    input wire logic        seq_int_ack,
    input wire logic        seq_int_high,
    input wire logic        seq_push,
    input wire logic        seq_pop,
    input wire logic        seq_low_write,
    input wire logic [20:0] pc,
    input wire logic [15:0] fetch_word,
    input wire logic        stack_reset,
    input wire logic [7:0]  stack_status,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_bvalid
);
    // pulses in priority order, so a lone op is easy to spot
    wire logic [7:0] ops = {seq_int_ack, seq_call, seq_jump, seq_return,
                            seq_push, seq_pop, seq_low_write, seq_advance};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_BIT5: assert property (stack_status[5] == 1'b0)
        else $error("status bit 5 not zero");
    AST_ALIGN: assert property (pc[0] == 1'b0)
        else $error("counter odd");
    AST_ADV: assert property (ops == 8'h01 && core_rst_n |=> pc == $past(pc) + 21'h000002)
        else $error("advance step wrong");
    AST_JUMP: assert property (seq_jump && ops[7:6] == 2'h0 && core_rst_n
        |=> pc == {$past(seq_target[20:1]), 1'b0}) else $error("jump target wrong");
    AST_VEC: assert property (seq_int_ack && core_rst_n
        |=> pc == (stack_reset ? 21'h000000 : $past(seq_int_high) ? 21'h000008 : 21'h000018))
        else $error("bad vector");
    AST_CORE: assert property (!core_rst_n |=> pc == 21'h000000 && stack_status[4:0] == 5'h00)
        else $error("core reset left state");
    AST_UNF: assert property (seq_return && ops[7:5] == 3'h0 && core_rst_n
        && stack_status[4:0] == 5'h00 |=> pc == 21'h000000 && stack_status[6])
        else $error("underflow not handled");
    AST_FULL: assert property (seq_push && ops[7:4] == 4'h0 && core_rst_n
        && stack_status[4:0] == 5'h1E |=> stack_status[7]) else $error("full flag missing");
    AST_HOLD: assert property ($past(rst_n) && ($fell(stack_status[7]) ||
        $fell(stack_status[6])) |-> $rose(s_axi_bvalid)) else $error("flag cleared without write");
    AST_FETCH: assert property ({1'b0, pc} >= PROG_BYTES |=> fetch_word == 16'h0000)
        else $error("fetch beyond memory not zero");
    AST_SRST: assert property (stack_reset |-> stack_status[7:6] != 2'h0)
        else $error("stack reset without flag");
    AST_RD: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule
bind pc_return_stack pc_return_stack_chk #(.PROG_BYTES(PROG_BYTES)) u_chk (.clk, .rst_n,
    .core_rst_n, .seq_advance, .seq_call, .seq_jump, .seq_target, .seq_return, .seq_int_ack,
    .seq_int_high, .seq_push, .seq_pop, .seq_low_write, .pc, .fetch_word, .stack_reset,
    .stack_status, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid);
`default_nettype wire

/* File: prog_mem.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// program memory model
// ****
module prog_mem (
    input  wire logic [20:0] pc,
    output logic      [15:0] mem_data
);
    // word scrambled from its address so a stale fetch is visible
    assign mem_data = pc[16:1] ^ 16'h5A3C;
endmodule
`default_nettype wire

/* File: pc_return_stack_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module pc_return_stack_tb;
    logic        clk, rst_n, aw_v, w_v, b_r, ar_v, r_r, aw_rdy, w_rdy, b_v, ar_rdy, r_v, srst;
    logic [9:0]  ops;
    logic [20:0] tgt, pc;
    logic [20:0] q[$];
    logic [7:0]  aw_a, ar_a, st;
    logic [15:0] fw, md;
    logic [31:0] w_d, r_d, seed, t, rv;
    logic [1:0]  rresp, rr, bresp, br;
    int          n, i, fail_count, cmp_count, cyc;
    // ops: 0 adv 1 call 2 jump 3 ret 4 int 5 push 6 pop 7 low wr 8 low rd 9 core reset
    pc_return_stack #(.PROG_BYTES(22'h010000)) u_dut (.clk(clk), .rst_n(rst_n),
        .core_rst_n(~ops[9]), .seq_advance(ops[0]), .seq_call(ops[1]), .seq_jump(ops[2]),
        .seq_target(tgt), .seq_return(ops[3]), .seq_int_ack(ops[4]), .seq_int_high(tgt[0]),
        .seq_push(ops[5]), .seq_pop(ops[6]), .seq_low_write(ops[7]),
        .seq_low_wdata(tgt[7:0]), .seq_low_read(ops[8]), .mem_data(md), .pc(pc),
        .fetch_word(fw), .stack_reset(srst), .stack_status(st), .s_axi_awaddr(aw_a),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(b_v),
        .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_d), .s_axi_rresp(rresp), .s_axi_rvalid(r_v), .s_axi_rready(r_r));
    prog_mem u_mem (.pc(pc), .mem_data(md));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] fexp(input logic [20:0] p);
        return (p < 21'h010000) ? {16'h0, p[16:1] ^ 16'h5A3C} : 32'h0;
    endfunction
    task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s exp %h got %h", s, exp, got);
        end
    endtask
    // one sequencer pulse, then wait for it to settle
    task automatic go(input logic [9:0] o, input logic [20:0] a);
        @(posedge clk);
        ops <= o;
        tgt <= a;
        @(posedge clk);
        ops <= 10'h000;
        @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        @(posedge clk);
        {aw_a, w_d, aw_v, w_v, b_r} <= {a, d, 3'h7};
        {aw, w} = 2'h3;
        while (aw || w) begin
            @(posedge clk);
            if (aw_rdy) aw = 1'b0;
            if (w_rdy) w = 1'b0;
            {aw_v, w_v} <= {aw, w};
        end
        do @(posedge clk); while (b_v !== 1'b1);
        br = bresp;
        b_r <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        {ar_a, ar_v, r_r} <= {a, 2'h3};
        do @(posedge clk); while (ar_rdy !== 1'b1);
        ar_v <= 1'b0;
        do @(posedge clk); while (r_v !== 1'b1);
        {rv, rr} = {r_d, rresp};
        r_r <= 1'b0;
        @(negedge clk);
        chk(s, rv, e);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        {rst_n, ops, tgt, aw_a, ar_a, w_d, aw_v, w_v, b_r, ar_v, r_r} = '0;
        {fail_count, cmp_count, cyc, seed} = {96'h0, 32'h000170AD};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("pc", pc, 32'h0);
        rc("status", 8'h0C, 32'h0);
        rc("config", 8'h1C, 32'h1);
        n = 1 + int'(xs() & 32'h7);
        repeat (n) go(10'h001, 21'h0);
        chk("advance", pc, 2 * n);
        $display("test advance done");
        for (i = 0; i < 2; i++) begin
            t = xs();
            if (i == 0) t[20:16] = 5'h00;
            else t[20] = 1'b1;
            go(10'h004, t[20:0]);
            chk("jump", pc, {t[20:1], 1'b0});
            @(negedge clk);
            chk("fetch", fw, fexp(pc));
        end
        go(10'h100, 21'h0);
        rc("hlatch", 8'h04, pc[15:8]);
        rc("ulatch", 8'h08, pc[20:16]);
        wr(8'h04, t[7:0]);
        wr(8'h08, t[12:8]);
        go(10'h002, xs());
        rc("hlatch", 8'h04, t[7:0]);
        go(10'h080, t[23:16]);
        chk("low write", pc, {t[12:8], t[7:0], t[23:17], 1'b0});
        $display("test latch done");
        go(10'h200, 21'h0);
        n = 2 + int'(xs() & 32'h3);
        repeat (n) begin
            q.push_back(pc);
            go(10'h002, xs());
        end
        // no interrupt while top is read
        rc("top low", 8'h10, q[$][7:0]);
        rc("top high", 8'h14, q[$][15:8]);
        rc("top upper", 8'h18, q[$][20:16]);
        rc("level", 8'h0C, n);
        while (q.size() > 0) begin
            go(10'h008, 21'h0);
            chk("return", pc, q.pop_back());
        end
        for (i = 0; i < 2; i++) begin
            go(10'h010, i);
            chk("vector", pc, i ? 32'h8 : 32'h18);
            go(10'h008, 21'h0);
        end
        $display("test stack done");
        repeat (30) go(10'h020, 21'h0);
        rc("status", 8'h0C, 32'h1E);
        go(10'h020, 21'h0);
        chk("ovf status", st, 32'h80);
        chk("ovf pc", pc, 32'h0);
        chk("ovf reset", srst, 32'h1);
        wr(8'h0C, 32'hC0);
        rc("status", 8'h0C, 32'h80);
        wr(8'h0C, 32'h0);
        rc("status", 8'h0C, 32'h0);
        wr(8'h1C, 32'h0);
        go(10'h200, 21'h0);
        repeat (31) go(10'h020, 21'h0);
        go(10'h001, 21'h0);
        go(10'h020, 21'h0);
        rc("status", 8'h0C, 32'h9F);
        rc("top low", 8'h10, 32'h0);
        go(10'h040, 21'h0);
        chk("pop", {pc, 3'h0, st}, {21'h2, 3'h0, 8'h9E});
        wr(8'h0C, 32'h0);
        go(10'h008, 21'h0);
        chk("underflow", {pc, 3'h0, st}, 32'h40);
        chk("unf no reset", srst, 32'h0);
        wr(8'h1C, 32'h1);
        go(10'h008, 21'h0);
        chk("unf reset", {srst, pc}, 32'h200000);
        rc("unmapped", 8'h20, 32'h0);
        chk("resp", rr, 32'h2);
        wr(8'h20, 32'h0);
        chk("wresp", br, 32'h2);
        $display("test overflow done");
        conclude();
    end
endmodule
`default_nettype wire
